// File: nvb_ctrl.sv
// Purpose: I/O register front end and timed write sequencer for a 512 byte data store
// Assumes: CPU drives one register access per cycle; inputs synchronous to CLK
// Notes: erased cells reset to all ones; write length counted in 1 MHz ticks
//
// Overview of operation
// - 512 bytes, nine bit linear address
// - Unused address and control bits read zero
// - Data register feeds writes, holds reads
// - Ready interrupt level while strobe clear
// - Master enable self clears after four cycles
// - Strobe starts write only under master enable
// - No write while flash programs
// - Write strobe stays set until done
// - Write lasts 8448 one MHz ticks
// - Write start stalls CPU two cycles
// - Read loads data, stalls four cycles
// - Busy write blocks reads and address
`timescale 1ns/100ps
module nvb_ctrl
	import nvb_pkg::*;
#(
	parameter int WRITE_TICKS = NVB_WRITE_TICKS,
	parameter int TICK_DIV = NVB_TICK_DIV
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire nvb_io_req_t IO_REQ,
	output logic [7:0] IO_RDATA,
	input wire logic GLOBAL_IRQ_EN,
	input wire logic FLASH_SELFPROG_ACTIVE,
	output logic READY_IRQ,
	output logic CPU_STALL
);
	initial begin
		if (WRITE_TICKS < 1 || TICK_DIV < 1) $error("nvb_ctrl: counts must be positive");
		if (WRITE_TICKS > 65535 || TICK_DIV > 255) $error("nvb_ctrl: counts too wide");
	end

	typedef enum logic [0:0] {NVB_IDLE, NVB_WRITING} nvb_state_t;

	////////////////////////////////////////////////////////////////////////////
	// Register state
	nvb_state_t state_q, state_d;
	logic [NVB_AW-1:0] addr_q, addr_d;
	logic [7:0] data_q, data_d;
	logic rie_q, rie_d;
	logic mwe_q, mwe_d;
	logic [2:0] mwe_cnt_q, mwe_cnt_d;
	logic [7:0] div_q, div_d;
	logic [15:0] tick_q, tick_d;
	logic [2:0] stall_q, stall_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] store_rdata;
	logic commit;
	logic wr_ctrl, wr_ws, wr_rs, wr_mwe, busy, start_wr, do_rd;

	nvb_store #(.DEPTH(NVB_DEPTH), .AW(NVB_AW)) u_store (
		.clk(CLK),
		.rst_n(RST_N),
		.we(commit),
		.waddr(addr_q),
		.wdata(data_q),
		.raddr(addr_q),
		.rdata(store_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		busy = (state_q == NVB_WRITING);
		wr_ctrl = IO_REQ.wr && (IO_REQ.addr == NVB_OFS_CTRL);
		wr_ws = wr_ctrl && IO_REQ.wdata[NVB_BIT_WS];
		wr_rs = wr_ctrl && IO_REQ.wdata[NVB_BIT_RS];
		wr_mwe = wr_ctrl && IO_REQ.wdata[NVB_BIT_MWE];
		start_wr = wr_ws && mwe_q && !busy && !FLASH_SELFPROG_ACTIVE;
		do_rd = wr_rs && !busy;
		state_d = state_q;
		addr_d = addr_q;
		data_d = data_q;
		rie_d = rie_q;
		mwe_d = mwe_q;
		mwe_cnt_d = mwe_cnt_q;
		div_d = div_q;
		tick_d = tick_q;
		stall_d = (stall_q != 3'h0) ? stall_q - 3'h1 : 3'h0;
		commit = 1'b0;
		if (IO_REQ.wr && !busy && IO_REQ.addr == NVB_OFS_ADDR_LOW) begin
			addr_d[7:0] = IO_REQ.wdata;
		end
		if (IO_REQ.wr && !busy && IO_REQ.addr == NVB_OFS_ADDR_HIGH) begin
			addr_d[8] = IO_REQ.wdata[0];
		end
		// Data held steady during a write so the committed byte is the one set up
		if (IO_REQ.wr && !busy && IO_REQ.addr == NVB_OFS_DATA) begin
			data_d = IO_REQ.wdata;
		end
		if (wr_ctrl) begin
			rie_d = IO_REQ.wdata[NVB_BIT_RIE];
		end
		if (mwe_q) begin
			if (mwe_cnt_q == 3'(NVB_MWE_WINDOW - 1)) begin
				mwe_d = 1'b0;
				mwe_cnt_d = 3'h0;
			end else begin
				mwe_cnt_d = mwe_cnt_q + 3'h1;
			end
		end
		if (wr_mwe && !mwe_q) begin
			mwe_d = 1'b1;
			mwe_cnt_d = 3'h0;
		end
		if (do_rd) begin
			data_d = store_rdata;
			stall_d = 3'(NVB_RD_STALL);
		end
		if (start_wr) begin
			state_d = NVB_WRITING;
			mwe_d = 1'b0;
			mwe_cnt_d = 3'h0;
			div_d = 8'h00;
			tick_d = 16'h0000;
			stall_d = 3'(NVB_WR_STALL);
		end
		if (busy) begin
			if (div_q == 8'(TICK_DIV - 1)) begin
				div_d = 8'h00;
				if (tick_q == 16'(WRITE_TICKS - 1)) begin
					state_d = NVB_IDLE;
					commit = 1'b1;
				end else begin
					tick_d = tick_q + 16'h0001;
				end
			end else begin
				div_d = div_q + 8'h01;
			end
		end
		case (IO_REQ.addr)
			NVB_OFS_ADDR_LOW: rdata_d = addr_d[7:0];
			NVB_OFS_ADDR_HIGH: rdata_d = {7'h00, addr_d[8]};
			NVB_OFS_DATA: rdata_d = data_d;
			NVB_OFS_CTRL: rdata_d = {4'h0, rie_d, mwe_d, state_d == NVB_WRITING, 1'b0};
			default: rdata_d = 8'h00;
		endcase
		if (!IO_REQ.rd) begin
			rdata_d = rdata_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	// strobes only cleared by hardware
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= NVB_IDLE;
			addr_q <= '0;
			data_q <= 8'h00;
			rie_q <= 1'b0;
			mwe_q <= 1'b0;
			mwe_cnt_q <= 3'h0;
			div_q <= 8'h00;
			tick_q <= 16'h0000;
			stall_q <= 3'h0;
			rdata_q <= 8'h00;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			data_q <= data_d;
			rie_q <= rie_d;
			mwe_q <= mwe_d;
			mwe_cnt_q <= mwe_cnt_d;
			div_q <= div_d;
			tick_q <= tick_d;
			stall_q <= stall_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign IO_RDATA = rdata_q;
	assign READY_IRQ = rie_q && GLOBAL_IRQ_EN && (state_q == NVB_IDLE);
	assign CPU_STALL = (stall_q != 3'h0);
endmodule : nvb_ctrl

// File: nvb_pkg.sv
// Purpose: shared constants and types for the byte-wide nonvolatile access controller
// Assumes: single 50 MHz clock; write timing derived from a 1 MHz tick
// Notes: register offsets are I/O register indices local to this block
package nvb_pkg;
	localparam int NVB_CLK_HZ = 50000000;
	localparam int NVB_TICK_HZ = 1000000;
	localparam int NVB_TICK_DIV = NVB_CLK_HZ / NVB_TICK_HZ;
	localparam int NVB_WRITE_TICKS = 8448;
	localparam int NVB_MWE_WINDOW = 4;
	localparam int NVB_WR_STALL = 2;
	localparam int NVB_RD_STALL = 4;
	localparam int NVB_DEPTH = 512;
	localparam int NVB_AW = 9;
	localparam logic [1:0] NVB_OFS_ADDR_LOW = 2'h0;
	localparam logic [1:0] NVB_OFS_ADDR_HIGH = 2'h1;
	localparam logic [1:0] NVB_OFS_DATA = 2'h2;
	localparam logic [1:0] NVB_OFS_CTRL = 2'h3;
	localparam int NVB_BIT_RIE = 3;
	localparam int NVB_BIT_MWE = 2;
	localparam int NVB_BIT_WS = 1;
	localparam int NVB_BIT_RS = 0;
	localparam logic [7:0] NVB_CTRL_RESET = 8'h00;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] addr;
		logic [7:0] wdata;
	} nvb_io_req_t;
endpackage : nvb_pkg

// File: nvb_store.sv
// Purpose: byte storage array of the nonvolatile controller
// Assumes: writes commit in one cycle when the timed write ends
// Notes: asynchronous read so read data is ready at once
`timescale 1ns/100ps
module nvb_store
	import nvb_pkg::*;
#(
	parameter int DEPTH = NVB_DEPTH,
	parameter int AW = NVB_AW
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem_q [DEPTH];
	logic [7:0] mem_d [DEPTH];
	initial begin
		if (DEPTH > (1 << AW)) $error("nvb_store: depth exceeds address range");
	end
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_cell
			always_comb begin
				mem_d[gi] = (we && (waddr == AW'(gi))) ? wdata : mem_q[gi];
			end
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					mem_q[gi] <= 8'hFF;
				end else begin
					mem_q[gi] <= mem_d[gi];
				end
			end
		end
	endgenerate
	assign rdata = mem_q[raddr];
endmodule : nvb_store

// File: nvb_ctrl_asserts.sv
// Purpose: port checks for nvb_ctrl
// Assumes: nvb_pkg register map
// Notes: busy is hidden, so checks tie outputs to bus causes
`timescale 1ns/100ps
module nvb_ctrl_asserts
	import nvb_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire nvb_io_req_t IO_REQ,
	input wire logic [7:0] IO_RDATA,
	input wire logic GLOBAL_IRQ_EN,
	input wire logic READY_IRQ,
	input wire logic CPU_STALL
);
	logic cw;
	logic rc;
	logic [2:0] age_q;
	logic [2:0] age_d;
	assign cw = IO_REQ.wr && IO_REQ.addr == NVB_OFS_CTRL;
	assign rc = IO_REQ.rd && IO_REQ.addr == NVB_OFS_CTRL;
	// Cycles since the last control write with the MWE bit set, saturating at 7
	always_comb begin
		age_d = (cw && IO_REQ.wdata[NVB_BIT_MWE]) ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
	end
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) age_q <= 3'h7;
		else age_q <= age_d;
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_irq_needs_gie: assert property (READY_IRQ |-> GLOBAL_IRQ_EN) else $error("irq no gie");
	a_irq_rie_off: assert property (cw && !IO_REQ.wdata[NVB_BIT_RIE] |=> !READY_IRQ) else $error("irq on");
	a_stall_min_two: assert property ($rose(CPU_STALL) |-> CPU_STALL[*2]) else $error("stall short");
	a_stall_max_four: assert property ($rose(CPU_STALL) |-> ##4 !CPU_STALL) else $error("stall long");
	a_stall_cause: assert property ($rose(CPU_STALL) |-> $past(cw)) else $error("stall cause");
	a_mwe_closes: assert property (rc && age_q > 3'h4 |=> !IO_RDATA[NVB_BIT_MWE]) else $error("mwe open");
	a_ctrl_res_zero: assert property (rc |=> IO_RDATA[7:4] == 4'h0 && !IO_RDATA[0]) else $error("ctrl bits");
	a_addr_hi_zero: assert property (IO_REQ.rd && IO_REQ.addr == NVB_OFS_ADDR_HIGH |=> IO_RDATA[7:1] == 7'h00)
		else $error("addr bits");
	c_write_start: cover property (cw && IO_REQ.wdata[NVB_BIT_WS]);
	c_irq_rise: cover property ($rose(READY_IRQ));
	c_late_read: cover property (rc && age_q > 3'h4);
endmodule : nvb_ctrl_asserts

// File: nvb_cpu_model.sv
// Purpose: cpu side register access model
// Assumes: called just after a rising edge
// Notes: a request holds until the next call
`timescale 1ns/100ps
module nvb_cpu_model
	import nvb_pkg::*;
(
	input wire logic CLK,
	output nvb_io_req_t REQ
);
	initial REQ = '0;
	task automatic io(input logic w, input logic [1:0] a, input logic [7:0] d);
		REQ <= '{w, !w, a, d};
		@(posedge CLK);
	endtask : io
	task automatic idle(input int n);
		REQ <= '0;
		repeat (n) @(posedge CLK);
	endtask : idle
endmodule : nvb_cpu_model

// File: nvb_ctrl_tb.sv
// Purpose: directed bench for nvb_ctrl
// Assumes: write shortened to 4 ticks of 2 clocks
// Notes: stall waits use the fixed stall lengths
`timescale 1ns/100ps
module nvb_ctrl_tb;
	import nvb_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic gie = 1'b0;
	logic fsa = 1'b0;
	logic [7:0] rdata;
	logic irq;
	logic stall;
	nvb_io_req_t req;
	int err_count = 0;
	int tests_run = 0;
	always #10 clk = ~clk;
	nvb_cpu_model cpu (.CLK(clk), .REQ(req));
	nvb_ctrl #(.WRITE_TICKS(4), .TICK_DIV(2)) uut (.CLK(clk), .RST_N(rst_n), .IO_REQ(req), .IO_RDATA(rdata),
		.GLOBAL_IRQ_EN(gie), .FLASH_SELFPROG_ACTIVE(fsa), .READY_IRQ(irq), .CPU_STALL(stall));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic r(input logic [1:0] a, input logic [7:0] e);
		cpu.io(1'b0, a, 8'h00);
		cpu.idle(1);
		chk(rdata, e);
	endtask : r
	task automatic start(input logic [8:0] a, input logic [7:0] d, input logic [7:0] c);
		cpu.io(1'b1, NVB_OFS_ADDR_HIGH, {7'h00, a[8]});
		cpu.io(1'b1, NVB_OFS_ADDR_LOW, a[7:0]);
		cpu.io(1'b1, NVB_OFS_DATA, d);
		cpu.io(1'b1, NVB_OFS_CTRL, c);
		cpu.io(1'b1, NVB_OFS_CTRL, c | 8'h02);
		cpu.idle(1);
		chk({7'h00, stall}, 8'h01);
		cpu.idle(1);
	endtask : start
	task automatic fetch(input logic [7:0] e);
		cpu.io(1'b1, NVB_OFS_CTRL, 8'h01);
		cpu.idle(5);
		r(NVB_OFS_DATA, e);
	endtask : fetch
	// Polls are two cycles apart, so the poll count pins the 8 cycle write
	task automatic wait_done(input int en);
		int n;
		n = 0;
		do begin
			cpu.io(1'b0, NVB_OFS_CTRL, 8'h00);
			cpu.idle(1);
			n++;
		end while (rdata[1] && n < 40);
		if (n >= 40) begin
			err_count++;
			summarize();
		end
		chk(8'(n), 8'(en));
	endtask : wait_done
	task automatic s_write;
		cpu.io(1'b1, NVB_OFS_ADDR_HIGH, 8'h00);
		cpu.io(1'b1, NVB_OFS_ADDR_LOW, 8'h00);
		fetch(8'hFF);
		start(9'h1FF, 8'hA5, 8'h04);
		r(NVB_OFS_CTRL, 8'h02);
		wait_done(3);
		r(NVB_OFS_ADDR_HIGH, 8'h01);
		fetch(8'hA5);
	endtask : s_write
	task automatic s_guard;
		cpu.io(1'b1, NVB_OFS_DATA, 8'h3C);
		cpu.io(1'b1, NVB_OFS_CTRL, 8'h02);
		r(NVB_OFS_CTRL, 8'h00);
		cpu.io(1'b1, NVB_OFS_CTRL, 8'h04);
		r(NVB_OFS_CTRL, 8'h04);
		cpu.idle(4);
		cpu.io(1'b1, NVB_OFS_CTRL, 8'h02);
		r(NVB_OFS_CTRL, 8'h00);
		fetch(8'hA5);
	endtask : s_guard
	task automatic s_busy;
		fsa <= 1'b1;
		cpu.io(1'b1, NVB_OFS_CTRL, 8'h04);
		cpu.io(1'b1, NVB_OFS_CTRL, 8'h06);
		r(NVB_OFS_CTRL, 8'h04);
		fsa <= 1'b0;
		gie <= 1'b1;
		start(9'h1FF, 8'h5A, 8'h0C);
		cpu.io(1'b1, NVB_OFS_CTRL, 8'h09);
		r(NVB_OFS_CTRL, 8'h0A);
		chk({7'h00, irq}, 8'h00);
		cpu.io(1'b1, NVB_OFS_ADDR_LOW, 8'h00);
		wait_done(2);
		chk({7'h00, irq}, 8'h01);
		r(NVB_OFS_ADDR_LOW, 8'hFF);
		r(NVB_OFS_DATA, 8'h5A);
		gie <= 1'b0;
		cpu.idle(1);
		chk({7'h00, irq}, 8'h00);
		gie <= 1'b1;
		cpu.io(1'b1, NVB_OFS_CTRL, 8'h00);
		cpu.idle(1);
		chk({7'h00, irq}, 8'h00);
		fetch(8'h5A);
	endtask : s_busy
	task automatic summarize;
		if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		s_write();
		s_guard();
		s_busy();
		summarize();
	end
endmodule : nvb_ctrl_tb
bind nvb_ctrl nvb_ctrl_asserts chk_i (.CLK(CLK), .RST_N(RST_N), .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA),
	.GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .READY_IRQ(READY_IRQ), .CPU_STALL(CPU_STALL));
